// ### logic/chc_flow_flags.sv
`timescale 1ns/1ps
module chc_flow_flags
  import chc_pkg::*;
#(
  parameter int W = 2
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // per-flag set and clear strobes
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // sticky flags
  output logic [W-1:0] flag
);

  // ----------------------------------------------------------------
  // sticky bits, one per flag
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      // set beats clear so an event in the clearing cycle survives
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          flag[i] <= 1'b0;
        else if (set[i])
          flag[i] <= 1'b1;
        else if (clr[i])
          flag[i] <= 1'b0;
      end

      property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        set[i] |=> flag[i];
      endproperty
      a_set_wins: assert property (p_set_wins)
        else $error("flow flag lost a set event");
    end
  endgenerate

endmodule

// ### logic/chc_pkg.sv
package chc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] CHC_OFF_STATUS = 32'hFFF80040;
  localparam logic [31:0] CHC_OFF_IRQ_SET = 32'hFFF80044;
  localparam logic [31:0] CHC_OFF_IRQ_CLR = 32'hFFF80048;
  localparam logic [31:0] CHC_OFF_IRQ_MASK = 32'hFFF8004C;
  localparam logic [31:0] CHC_OFF_DMA_CFG = 32'hFFF80050;
  localparam logic [31:0] CHC_OFF_HOST_CFG = 32'hFFF80054;

  // ----------------------------------------------------------------
  // flag positions and implemented flag bits
  // ----------------------------------------------------------------
  localparam int CHC_BIT_CMD_DONE = 0;
  localparam int CHC_BIT_RX_OVERRUN = 30;
  localparam int CHC_BIT_TX_UNDERRUN = 31;
  localparam logic [31:0] CHC_FLAG_USED = 32'hFFFF313F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CHC_DMA_OFFSET_LSB = 0;
  localparam int CHC_DMA_CHUNK_LSB = 4;
  localparam int CHC_DMA_ENABLE_BIT = 8;
  localparam int CHC_DMA_READ_PAD_OPTIMIZE_BIT = 12;
  localparam int CHC_CFG_FIFO_BIT = 0;
  localparam int CHC_CFG_FERR_BIT = 4;
  localparam int CHC_CFG_HS_BIT = 8;
  localparam int CHC_CFG_LAST_BLOCK_SYNC_BIT = 12;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CHC_MASK_RESET = 32'h00000000;
  localparam logic [5:0] CHC_DMA_RESET = 6'h00;
  localparam logic [3:0] CHC_CFG_RESET = 4'h0;

  // ----------------------------------------------------------------
  // chunk sizes in data items
  // ----------------------------------------------------------------
  localparam logic [4:0] CHC_CHUNK_1 = 5'h01;
  localparam logic [4:0] CHC_CHUNK_4 = 5'h04;
  localparam logic [4:0] CHC_CHUNK_8 = 5'h08;
  localparam logic [4:0] CHC_CHUNK_16 = 5'h10;

  typedef struct packed {
    logic read_pad_optimize;
    logic dma_handshake_enable;
    logic [1:0] dma_chunk_size;
    logic [1:0] write_offset;
  } chc_dma_cfg_t;

  typedef struct packed {
    logic last_block_sync;
    logic high_speed_timing;
    logic flow_error_clear_mode;
    logic fifo_write_start_mode;
  } chc_host_cfg_t;

  typedef enum logic [1:0] {
    CHC_IDLE,
    CHC_WAIT_BLOCK,
    CHC_WAIT_XFER
  } chc_cmd_state_t;

endpackage

// ### logic/chc_regs.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module chc_regs
  import chc_pkg::*;
#(
  parameter int FIFO_WORDS = 64,
  parameter int BLEN_W = 16,
  parameter int FILL_W = 8
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status from the controller core
  input wire logic [31:0] core_flags,
  input wire logic underrun_event,
  input wire logic overrun_event,
  input wire logic new_xfer_cmd,
  // data path
  input wire logic [BLEN_W-1:0] block_length,
  input wire logic [FILL_W-1:0] fifo_fill,
  output chc_dma_cfg_t dma_cfg,
  output chc_host_cfg_t host_cfg,
  output logic [4:0] dma_chunk_items,
  output logic [BLEN_W:0] read_move_bytes,
  output logic [FILL_W-1:0] write_start_level,
  output logic write_start,
  // command sequencing
  input wire logic cmd_pending,
  input wire logic block_end,
  input wire logic xfer_end,
  input wire logic block_count_zero,
  output logic issue_cmd,
  // interrupt request
  output logic irq
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic acc_first = psel && penable && !pready;
  wire logic acc_done = psel && penable && pready;
  wire logic hit_status = paddr == CHC_OFF_STATUS;
  wire logic hit_set = paddr == CHC_OFF_IRQ_SET;
  wire logic hit_clr = paddr == CHC_OFF_IRQ_CLR;
  wire logic hit_mask = paddr == CHC_OFF_IRQ_MASK;
  wire logic hit_dma = paddr == CHC_OFF_DMA_CFG;
  wire logic hit_cfg = paddr == CHC_OFF_HOST_CFG;
  wire logic rd_ok = hit_status || hit_mask || hit_dma || hit_cfg;
  wire logic wr_ok = hit_set || hit_clr || hit_dma || hit_cfg;
  wire logic bad = pwrite ? !wr_ok : !rd_ok;
  wire logic wr_commit = acc_done && pwrite && !pslverr;
  // the read-clear is taken with the data capture so no event slips by
  wire logic status_read = acc_first && !pwrite && hit_status;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] irq_mask;
  logic [1:0] flow_flag;
  wire logic [31:0] dma_word = {19'h0, dma_cfg.read_pad_optimize,
    3'h0, dma_cfg.dma_handshake_enable, 2'h0, dma_cfg.dma_chunk_size,
    2'h0, dma_cfg.write_offset};
  wire logic [31:0] cfg_word = {19'h0, host_cfg.last_block_sync, 3'h0,
    host_cfg.high_speed_timing, 3'h0, host_cfg.flow_error_clear_mode,
    3'h0, host_cfg.fifo_write_start_mode};

  // underrun and overrun held here, rest are core levels
  wire logic [31:0] status_word = {flow_flag[1], flow_flag[0],
    core_flags[29:0]} & CHC_FLAG_USED;

  wire logic [31:0] next_rdata = hit_status ? status_word :
                                 hit_mask ? irq_mask :
                                 hit_dma ? dma_word :
                                 hit_cfg ? cfg_word : 32'h00000000;

  wire logic [31:0] set_bits = pwdata & CHC_FLAG_USED;
  wire logic [31:0] next_mask =
    wr_commit && hit_set ? irq_mask | set_bits :
    wr_commit && hit_clr ? irq_mask & ~set_bits :
    irq_mask;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= acc_first;
      pslverr <= acc_first && bad;
      if (acc_first && !pwrite)
        prdata <= bad ? 32'h00000000 : next_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= CHC_MASK_RESET;
    else
      irq_mask <= next_mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dma_cfg <= CHC_DMA_RESET;
    else if (wr_commit && hit_dma)
    begin
      dma_cfg.write_offset <= pwdata[CHC_DMA_OFFSET_LSB+:2];
      dma_cfg.dma_chunk_size <= pwdata[CHC_DMA_CHUNK_LSB+:2];
      dma_cfg.dma_handshake_enable <= pwdata[CHC_DMA_ENABLE_BIT];
      dma_cfg.read_pad_optimize <= pwdata[CHC_DMA_READ_PAD_OPTIMIZE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      host_cfg <= CHC_CFG_RESET;
    else if (wr_commit && hit_cfg)
    begin
      host_cfg.fifo_write_start_mode <= pwdata[CHC_CFG_FIFO_BIT];
      host_cfg.flow_error_clear_mode <= pwdata[CHC_CFG_FERR_BIT];
      host_cfg.high_speed_timing <= pwdata[CHC_CFG_HS_BIT];
      host_cfg.last_block_sync <= pwdata[CHC_CFG_LAST_BLOCK_SYNC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // flow error flags
  // ----------------------------------------------------------------
  wire logic ferr_write = wr_commit && hit_cfg && pwdata[CHC_CFG_FERR_BIT];
  wire logic ferr_read = status_read && host_cfg.flow_error_clear_mode;
  // a new command clears both; a read clears only in ferr mode
  wire logic under_clr = new_xfer_cmd || ferr_write || ferr_read;
  wire logic over_clr = new_xfer_cmd || ferr_read;

  chc_flow_flags #(
    .W(2)
  ) u_flow (
    .pclk(pclk),
    .presetn(presetn),
    .set({underrun_event, overrun_event}),
    .clr({under_clr, over_clr}),
    .flag(flow_flag)
  );

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(status_word & irq_mask);
  end

  // ----------------------------------------------------------------
  // dma and fifo helpers
  // ----------------------------------------------------------------
  wire logic [4:0] chunk_items =
    dma_cfg.dma_chunk_size == 2'b00 ? CHC_CHUNK_1 :
    dma_cfg.dma_chunk_size == 2'b01 ? CHC_CHUNK_4 :
    dma_cfg.dma_chunk_size == 2'b10 ? CHC_CHUNK_8 : CHC_CHUNK_16;

  wire logic [BLEN_W:0] blen_x = {1'b0, block_length};
  wire logic [BLEN_W:0] blen_pad = (blen_x + (BLEN_W+1)'(3)) &
                                   ~(BLEN_W+1)'(3);
  wire logic [BLEN_W:0] next_move = dma_cfg.read_pad_optimize ?
    blen_pad :
    blen_x;

  wire logic [FILL_W-1:0] level;

  chc_write_start #(
    .FIFO_WORDS(FIFO_WORDS),
    .BLEN_W(BLEN_W),
    .FILL_W(FILL_W)
  ) u_start (
    .fifo_write_start_mode(host_cfg.fifo_write_start_mode),
    .block_length(block_length),
    .level(level)
  );

  // limitation: outputs trail the config write by one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_chunk_items <= CHC_CHUNK_1;
      read_move_bytes <= '0;
      write_start_level <= '0;
      write_start <= 1'b0;
    end
    else
    begin
      dma_chunk_items <= chunk_items;
      read_move_bytes <= next_move;
      write_start_level <= level;
      write_start <= fifo_fill >= level && fifo_fill != '0;
    end
  end

  // ----------------------------------------------------------------
  // pending command sequencing
  // ----------------------------------------------------------------
  chc_cmd_state_t state;
  chc_cmd_state_t next_state;
  // infinite transfers never end, so sync falls back to block end
  wire logic sync_xfer = host_cfg.last_block_sync && !block_count_zero;
  logic next_issue;

  always_comb
  begin
    next_state = state;
    next_issue = 1'b0;
    case (state)
      CHC_IDLE:
        if (cmd_pending)
          next_state = sync_xfer ? CHC_WAIT_XFER : CHC_WAIT_BLOCK;
      CHC_WAIT_BLOCK:
        if (block_end)
        begin
          next_issue = 1'b1;
          next_state = CHC_IDLE;
        end
      CHC_WAIT_XFER:
        if (xfer_end)
        begin
          next_issue = 1'b1;
          next_state = CHC_IDLE;
        end
      default:
        next_state = CHC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= CHC_IDLE;
      issue_cmd <= 1'b0;
    end
    else
    begin
      state <= next_state;
      issue_cmd <= next_issue;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_status_read_ferr;
    status_read && host_cfg.flow_error_clear_mode && !underrun_event;
  endsequence

  property p_read_clears_under;
    s_status_read_ferr |=> !flow_flag[1];
  endproperty
  a_read_clears_under: assert property (p_read_clears_under)
    else $error("underrun survived a status read");

  property p_read_clears_over;
    status_read && host_cfg.flow_error_clear_mode && !overrun_event
      |=> !flow_flag[0];
  endproperty
  a_read_clears_over: assert property (p_read_clears_over)
    else $error("overrun survived a status read");

  property p_flag_holds;
    flow_flag[0] && !new_xfer_cmd && !ferr_read |=> flow_flag[0];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("overrun cleared without cause");

  property p_set_mask;
    wr_commit && hit_set |=> (irq_mask & $past(set_bits)) == $past(set_bits);
  endproperty
  a_set_mask: assert property (p_set_mask)
    else $error("enable write did not set mask bits");

  property p_clr_mask;
    wr_commit && hit_clr |=> (irq_mask & $past(set_bits)) == 32'h00000000;
  endproperty
  a_clr_mask: assert property (p_clr_mask)
    else $error("disable write did not clear mask bits");

  property p_mask_read;
    acc_first && !pwrite && hit_mask |=> prdata == $past(irq_mask);
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read returned wrong value");

  property p_irq;
    ##1 irq == |($past(status_word) & $past(irq_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq does not follow flags and mask");

  property p_chunk;
    dma_cfg.dma_chunk_size == 2'b11 |=> dma_chunk_items == CHC_CHUNK_16;
  endproperty
  a_chunk: assert property (p_chunk)
    else $error("chunk size decode wrong");

  property p_pad;
    dma_cfg.read_pad_optimize |=> read_move_bytes[1:0] == 2'b00;
  endproperty
  a_pad: assert property (p_pad)
    else $error("padded length not a multiple of four");

  sequence s_wait_block;
    state == CHC_WAIT_BLOCK && block_end;
  endsequence

  property p_block_issue;
    s_wait_block |=> issue_cmd ##1 !issue_cmd;
  endproperty
  a_block_issue: assert property (p_block_issue)
    else $error("pending command not issued at block end");

  property p_xfer_hold;
    state == CHC_WAIT_XFER && !xfer_end |=> !issue_cmd;
  endproperty
  a_xfer_hold: assert property (p_xfer_hold)
    else $error("command issued before transfer end");

  property p_fifo_mode;
    host_cfg.fifo_write_start_mode |-> level == FILL_W'(1);
  endproperty
  a_fifo_mode: assert property (p_fifo_mode)
    else $error("fifo mode level is not one item");

  if (BLEN_W < 4 || FILL_W < 3)
    $error("length or fill width too small");

endmodule

// ### logic/chc_write_start.sv
`timescale 1ns/1ps
module chc_write_start
  import chc_pkg::*;
#(
  parameter int FIFO_WORDS = 64,
  parameter int BLEN_W = 16,
  parameter int FILL_W = 8
)
(
  // configuration
  input wire logic fifo_write_start_mode,
  input wire logic [BLEN_W-1:0] block_length,
  // fill level in words at which a card write may start
  output logic [FILL_W-1:0] level
);

  // ----------------------------------------------------------------
  // thresholds in bytes: 3/4 fifo is 3*words, half is 2*words
  // ----------------------------------------------------------------
  localparam logic [BLEN_W+1:0] THREE_Q = (BLEN_W+2)'(3 * FIFO_WORDS);
  localparam logic [BLEN_W+1:0] HALF_B = (BLEN_W+2)'(2 * FIFO_WORDS);
  localparam logic [FILL_W-1:0] LVL_HALF = FILL_W'(FIFO_WORDS / 2);
  localparam logic [FILL_W-1:0] LVL_QUART = FILL_W'(FIFO_WORDS / 4);
  localparam logic [FILL_W-1:0] LVL_ONE = FILL_W'(1);

  wire logic [BLEN_W+1:0] blen_x = {2'b00, block_length};
  // whole small block, rounded up to words
  wire logic [BLEN_W+1:0] blen_words = (blen_x + (BLEN_W+2)'(3)) >> 2;
  wire logic big_block = blen_x >= THREE_Q;
  wire logic mid_block = blen_x >= HALF_B;

  assign level = fifo_write_start_mode ? LVL_ONE :
                 big_block ? LVL_HALF :
                 mid_block ? LVL_QUART :
                 blen_words[FILL_W-1:0];

  if (FIFO_WORDS < 4 || FIFO_WORDS >= (1 << FILL_W))
    $error("fifo depth does not fit the fill counter");

endmodule

// ### verif/chc_core_model.sv
`timescale 1ns/1ps
module chc_core_model
  import chc_pkg::*;
(
  // clock
  input wire logic pclk,
  // strobes: underrun, overrun, new command, pending, block end, xfer end
  output logic [5:0] pulse
);
  initial
  begin
    pulse = 6'h00;
  end

  // lost and unwritten bytes arrive as bare events; no card traffic
  // is modelled, so flags rise without any data moving
  task automatic fire(input int i);
    pulse[i] <= 1'b1;
    @(posedge pclk);
    pulse[i] <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ### verif/tb_chc_regs.sv
`timescale 1ns/1ps
module tb_chc_regs
  import chc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [31:0] paddr, pwdata, prdata, flags, rd;
  logic pready, pslverr, irq, write_start, issue_cmd, bcz;
  logic [5:0] pulse;
  logic [15:0] blen;
  logic [7:0] fill, level;
  logic [4:0] items;
  logic [16:0] move;
  chc_dma_cfg_t dma_cfg;
  chc_host_cfg_t host_cfg;
  int failures, comparisons, cycles, issues, iss;
  logic [31:0] d;

  chc_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_flags(flags), .underrun_event(pulse[0]),
    .overrun_event(pulse[1]), .new_xfer_cmd(pulse[2]),
    .block_length(blen), .fifo_fill(fill), .dma_cfg(dma_cfg),
    .host_cfg(host_cfg), .dma_chunk_items(items),
    .read_move_bytes(move), .write_start_level(level),
    .write_start(write_start), .cmd_pending(pulse[3]),
    .block_end(pulse[4]), .xfer_end(pulse[5]),
    .block_count_zero(bcz), .issue_cmd(issue_cmd), .irq(irq));

  chc_core_model core (.pclk(pclk), .pulse(pulse));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----
  // helpers
  // ----
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // the run should take well under a thousand cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (issue_cmd === 1'b1)
      issues++;
    if (cycles == 5000)
    begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; pready is read before that
  // edge's updates land, which is the value the edge samples
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16)
      failures++;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, bcz} = 4'h0;
    {paddr, pwdata, flags} = '0;
    blen = 16'h0000;
    fill = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(CHC_OFF_IRQ_MASK, CHC_MASK_RESET);
    rdchk(CHC_OFF_DMA_CFG, 32'h0);
    rdchk(CHC_OFF_HOST_CFG, 32'h0);
    check(items, 32'h1);
    $display("test reset done");
    apb(1'b1, CHC_OFF_IRQ_SET, 32'hFFFFFFFF);
    rdchk(CHC_OFF_IRQ_MASK, CHC_FLAG_USED);
    apb(1'b1, CHC_OFF_IRQ_CLR, 32'h80000001);
    rdchk(CHC_OFF_IRQ_MASK, 32'h7FFF313E);
    apb(1'b1, CHC_OFF_IRQ_SET, 32'h0);
    rdchk(CHC_OFF_IRQ_MASK, 32'h7FFF313E);
    apb(1'b1, CHC_OFF_IRQ_CLR, 32'h0);
    rdchk(CHC_OFF_IRQ_MASK, 32'h7FFF313E);
    apb(1'b1, CHC_OFF_IRQ_MASK, 32'h0);
    check(err, 32'h1);
    rdchk(CHC_OFF_IRQ_MASK, 32'h7FFF313E);
    flags <= 32'h00000001;
    settle();
    check(irq, 32'h0);
    apb(1'b1, CHC_OFF_IRQ_SET, 32'h1);
    settle();
    check(irq, 32'h1);
    apb(1'b1, CHC_OFF_IRQ_CLR, 32'hFFFFFFFF);
    settle();
    check(irq, 32'h0);
    // core levels on 31 and 30 are ignored, unused positions read zero
    flags <= 32'hFFFFFFFF;
    settle();
    rdchk(CHC_OFF_STATUS, 32'h3FFF313F);
    flags <= 32'h0;
    $display("test mask done");
    core.fire(0);
    rdchk(CHC_OFF_STATUS, 32'h80000000);
    rdchk(CHC_OFF_STATUS, 32'h80000000);
    core.fire(2);
    rdchk(CHC_OFF_STATUS, 32'h0);
    core.fire(0);
    apb(1'b1, CHC_OFF_HOST_CFG, 32'h10);
    rdchk(CHC_OFF_STATUS, 32'h0);
    core.fire(0);
    core.fire(1);
    rdchk(CHC_OFF_STATUS, 32'hC0000000);
    rdchk(CHC_OFF_STATUS, 32'h0);
    $display("test flow flags done");
    // no processor data moves while the handshake is on
    for (int c = 0; c < 4; c++)
    begin
      d = 32'h100 | (c << 4) | c | ((c & 1) << 12);
      apb(1'b1, CHC_OFF_DMA_CFG, d);
      rdchk(CHC_OFF_DMA_CFG, d);
      settle();
      check(items, (c == 0) ? 32'h1 : (32'h2 << c));
      check(dma_cfg.write_offset, c[1:0]);
      check(dma_cfg.dma_handshake_enable, 32'h1);
    end
    apb(1'b1, CHC_OFF_DMA_CFG, 32'hFFFFFFFF);
    rdchk(CHC_OFF_DMA_CFG, 32'h00001133);
    blen <= 16'h000D;
    apb(1'b1, CHC_OFF_DMA_CFG, 32'h0);
    settle();
    check(dma_cfg.dma_handshake_enable, 32'h0);
    check(move, 32'hD);
    apb(1'b1, CHC_OFF_DMA_CFG, 32'h1000);
    settle();
    check(move, 32'h10);
    $display("test dma done");
    apb(1'b1, CHC_OFF_HOST_CFG, 32'h0);
    blen <= 16'h00C0;
    fill <= 8'h1F;
    settle();
    check(level, 32'h20);
    check(write_start, 32'h0);
    fill <= 8'h20;
    settle();
    check(write_start, 32'h1);
    blen <= 16'h00BF;
    settle();
    check(level, 32'h10);
    blen <= 16'h0028;
    settle();
    check(level, 32'hA);
    apb(1'b1, CHC_OFF_HOST_CFG, 32'h1);
    fill <= 8'h01;
    settle();
    check(level, 32'h1);
    check(write_start, 32'h1);
    $display("test write start done");
    apb(1'b1, CHC_OFF_HOST_CFG, 32'hFFFFFFFF);
    rdchk(CHC_OFF_HOST_CFG, 32'h00001111);
    // the card is taken to support high speed before the mode is set
    apb(1'b1, CHC_OFF_HOST_CFG, 32'h100);
    settle();
    check(host_cfg.high_speed_timing, 32'h1);
    apb(1'b1, CHC_OFF_HOST_CFG, 32'h0);
    settle();
    check(host_cfg.high_speed_timing, 32'h0);
    iss = issues;
    core.fire(3);
    core.fire(4);
    settle();
    check(32'(issues), 32'(iss + 1));
    apb(1'b1, CHC_OFF_HOST_CFG, 32'h1000);
    core.fire(3);
    core.fire(4);
    settle();
    check(32'(issues), 32'(iss + 1));
    core.fire(5);
    settle();
    check(32'(issues), 32'(iss + 2));
    // infinite transfer: sync falls back to block end
    bcz <= 1'b1;
    core.fire(3);
    core.fire(4);
    settle();
    check(32'(issues), 32'(iss + 3));
    bcz <= 1'b0;
    $display("test command done");
    apb(1'b0, CHC_OFF_IRQ_SET, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    apb(1'b0, 32'hFFF80058, 32'h0);
    check(err, 32'h1);
    $display("test refused done");
    stop_test();
  end
endmodule
